// ---- hw/nal_alu.sv ----
// Combinational 4-bit ALU: binary and decimal arithmetic, logic, tests, compare, rotate.
// Assumes its operands come from the temporary registers and flags from the status word.
`timescale 1ns/100ps

module nal_alu (
    // Operation and operands.
    input wire nal_pkg::nal_op_t op_i,
    input wire logic [3:0] a_i,
    input wire logic [3:0] b_i,
    // Current flags.
    input wire logic carry_i,
    input wire logic decimal_i,
    // Results.
    output logic [3:0] result_o,
    output logic carry_o,
    output logic skip_o
);

    // Decimal correction of a 5-bit binary sum.
    function automatic logic [4:0] bcd_add_fix(input logic [4:0] s);
        logic [4:0] fixed;
        fixed = s;
        if (s < 5'd10)
            fixed = s;
        else if (s < 5'd20)
            fixed = {1'b1, 4'(s[3:0] + 4'h6)};
        else if (s < 5'd28)
            fixed = {3'b111, 2'(s[1:0] + 2'b10)};
        else
            fixed = {1'b1, 4'(s[3:0] + 4'he)};
        return fixed;
    endfunction : bcd_add_fix

    // Decimal correction of a 5-bit two's-complement difference.
    function automatic logic [4:0] bcd_sub_fix(input logic [4:0] d);
        logic [4:0] fixed;
        fixed = d;
        if (!d[4] && d[3:0] < 4'ha)
            fixed = d;
        else if (d[4] && d[3:0] >= 4'h6)
            fixed = {1'b1, 4'(d[3:0] - 4'h6)};
        else
            fixed = {3'b111, 2'(d[1:0] + 2'b10)};
        return fixed;
    endfunction : bcd_sub_fix

    // Carry or borrow injected into the lowest bit for the with-carry forms.
    logic carry_in;
    // Raw binary sum and difference, one extra bit for carry or borrow.
    logic [4:0] sum;
    logic [4:0] diff;
    // Plain compare difference, never corrected.
    logic [4:0] compare_diff;

    // Arithmetic core shared by all subtracting and adding operations.
    always_comb
    begin
        carry_in = (op_i == nal_pkg::OP_ADDC || op_i == nal_pkg::OP_SUBC) ? carry_i : 1'b0; // RULE5
        sum = 5'({1'b0, a_i} + {1'b0, b_i} + {4'h0, carry_in});
        diff = 5'({1'b0, a_i} - {1'b0, b_i} - {4'h0, carry_in});
        compare_diff = 5'({1'b0, a_i} - {1'b0, b_i}); // RULE15
    end

    // Result, carry and skip selection per operation.
    always_comb
    begin
        result_o = a_i;
        carry_o = carry_i;
        skip_o = 1'b0;
        case (op_i)
            nal_pkg::OP_ADD, nal_pkg::OP_ADDC:
            begin
                // Decimal mode corrects the sum and its carry.
                {carry_o, result_o} = decimal_i ? bcd_add_fix(sum) : sum; // RULE4 RULE13
            end
            nal_pkg::OP_SUB, nal_pkg::OP_SUBC:
            begin
                // Borrow is the sign bit of the difference.
                {carry_o, result_o} = decimal_i ? bcd_sub_fix(diff) : diff; // RULE4 RULE13
            end
            nal_pkg::OP_OR:
                result_o = a_i | b_i;
            nal_pkg::OP_AND:
                result_o = a_i & b_i;
            nal_pkg::OP_XOR:
                result_o = a_i ^ b_i;
            nal_pkg::OP_TEST_ONES:
                skip_o = ((a_i & b_i) == b_i);
            nal_pkg::OP_TEST_ZEROS:
                skip_o = ((a_i & b_i) == 4'h0);
            nal_pkg::OP_SKIP_EQ:
                skip_o = (compare_diff[3:0] == 4'h0); // RULE15 RULE14
            nal_pkg::OP_SKIP_NE:
                skip_o = (compare_diff[3:0] != 4'h0); // RULE15
            nal_pkg::OP_SKIP_GE:
                skip_o = !compare_diff[4]; // RULE15
            nal_pkg::OP_SKIP_LT:
                skip_o = compare_diff[4]; // RULE15
            nal_pkg::OP_ROTATE:
            begin
                // Old carry enters bit 3, bit 0 leaves into carry.
                result_o = {carry_i, a_i[3:1]}; // RULE6
                carry_o = a_i[0]; // RULE6
            end
            default:
            begin
                result_o = a_i;
            end
        endcase
    end

endmodule : nal_alu

// ---- hw/nal_operand_latch.sv ----
// Temporary operand registers A and B that feed the ALU during execution.
// Assumes load_i is a one-cycle pulse from logic on the same clock.
`timescale 1ns/100ps

module nal_operand_latch #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    // Load strobe and incoming operands.
    input wire logic load_i,
    input wire logic [WIDTH-1:0] first_i,
    input wire logic [WIDTH-1:0] second_i,
    // Held operands.
    output logic [WIDTH-1:0] temp_a_o,
    output logic [WIDTH-1:0] temp_b_o
);

    // Temporary register A keeps the first operand.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            temp_a_o <= '0;
        else if (load_i)
            temp_a_o <= first_i; // RULE11
    end

    // Temporary register B keeps the second operand.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            temp_b_o <= '0;
        else if (load_i)
            temp_b_o <= second_i; // RULE11
    end

endmodule : nal_operand_latch

// ---- hw/nal_pkg.sv ----
// Constants, operation codes and state encoding for the nibble ALU status block.
// Assumes a single 20 MHz core clock and an APB master that owns the status word.
// How it works
// RULE1 - no_store clear: zero result sets null flag
// RULE2 - no_store set: zero holds, nonzero clears
// RULE3 - Null flag changes on arithmetic only
// RULE4 - Arithmetic sets carry on carry or borrow
// RULE5 - With-carry ops inject carry flag as LSB
// RULE6 - Rotate: carry to bit3, bit0 to carry
// RULE7 - Carry changes on arithmetic and rotate only
// RULE8 - no_store set: arithmetic result never written
// RULE9 - Bit tests clear the no_store flag
// RULE10 - no_store ignored by compare, logic, rotate
// RULE11 - Operands latched into two temporary registers
// RULE12 - Flags and status word are one storage
// RULE13 - Decimal mode corrects every arithmetic result
// RULE14 - Decimal mode ignored outside arithmetic
// RULE15 - Compare subtracts, skips by opcode condition
// RULE16 - Flags and write commit together, end of execute
// RULE17 - Logic ops write result, hold all flags
package nal_pkg;

    // Width of one data nibble.
    localparam int NIBBLE_W = 4;

    // Operation codes presented by the instruction sequencer.
    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_ADDC = 4'h1,
        OP_SUB = 4'h2,
        OP_SUBC = 4'h3,
        OP_OR = 4'h4,
        OP_AND = 4'h5,
        OP_XOR = 4'h6,
        OP_TEST_ONES = 4'h7,
        OP_TEST_ZEROS = 4'h8,
        OP_SKIP_EQ = 4'h9,
        OP_SKIP_NE = 4'ha,
        OP_SKIP_GE = 4'hb,
        OP_SKIP_LT = 4'hc,
        OP_ROTATE = 4'hd
    } nal_op_t;

    // Execution sequencer states, Gray coded.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01
    } nal_state_t;

    // APB register byte offsets.
    localparam logic [7:0] ADDR_STATUS_WORD = 8'h00;
    localparam logic [7:0] ADDR_LAST_RESULT = 8'h04;

    // Bit positions inside the program status word.
    localparam int BIT_NULL = 0;
    localparam int BIT_CARRY = 1;
    localparam int BIT_NO_STORE = 2;
    localparam int BIT_DECIMAL = 3;

    // Field positions inside the last-result register.
    localparam int LAST_SKIP_BIT = 4;
    localparam int LAST_BUSY_BIT = 8;

    // Reset values.
    localparam logic [3:0] STATUS_WORD_RESET = 4'h0;
    localparam logic [3:0] RESULT_RESET = 4'h0;

endpackage : nal_pkg

// ---- hw/nal_status_alu.sv ----
// Top of the nibble ALU status block: operand latching, one execute cycle,
// flag update and result write control, and an APB view of the status word.
// Assumes the sequencer starts one instruction at a time with start_i while ready_o
// is high, and that general register and data memory accept the write pulses.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/100ps

module nal_status_alu #(
    parameter int DATA_W = nal_pkg::NIBBLE_W
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    // Instruction request from the sequencer.
    input wire logic start_i,
    input wire nal_pkg::nal_op_t op_i,
    input wire logic dest_mem_i,
    input wire logic [3:0] first_i,
    input wire logic [3:0] second_i,
    output logic ready_o,
    // Completion and result towards register and memory.
    output logic done_o,
    output logic [3:0] result_o,
    output logic gr_write_o,
    output logic mem_write_o,
    output logic skip_o,
    // Flags as seen by the rest of the core.
    output logic null_flag_o,
    output logic carry_flag_o,
    output logic no_store_flag_o,
    output logic decimal_flag_o,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration check

    // The flag and decimal logic is written for one nibble only.
    if (DATA_W != 4)
    begin : g_width_check
        $error("nal_status_alu supports only a 4-bit data path");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Sequencer state and its next value.
    nal_pkg::nal_state_t state_reg;
    nal_pkg::nal_state_t state_next;
    // Operation and destination held for the execute cycle.
    nal_pkg::nal_op_t op_reg;
    logic dest_mem_reg;
    // Temporary operands A and B.
    logic [3:0] temp_a;
    logic [3:0] temp_b;
    // The status word itself; its bits are the ALU flags.
    logic [3:0] status_word_reg;
    logic [3:0] status_word_next;
    // Combinational ALU answers.
    logic [3:0] alu_result;
    logic alu_carry;
    logic alu_skip;
    // Operation class decode of the held operation.
    logic is_arith;
    logic is_logic;
    logic is_test;
    logic is_rotate;
    // Commit strobe in the execute cycle.
    logic commit;
    // Start accepted in this cycle.
    logic accept;
    // APB phase strobes.
    logic apb_setup;
    logic apb_write;
    logic apb_mapped;
    // Registered copies of the last answer.
    logic [3:0] result_reg;
    logic skip_reg;
    logic done_reg;
    logic gr_write_reg;
    logic mem_write_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Operand latches and ALU

    // The sequencer hands operands over only when a start is accepted.
    assign accept = start_i && (state_reg == nal_pkg::ST_IDLE);
    assign ready_o = (state_reg == nal_pkg::ST_IDLE);

    // Operands A and B are captured at the accepting edge.
    nal_operand_latch #(
        .WIDTH(4)
    ) u_latch (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .load_i(accept),
        .first_i(first_i),
        .second_i(second_i),
        .temp_a_o(temp_a),
        .temp_b_o(temp_b)
    );

    // The ALU reads the registered status word, so a software write is seen from the next cycle.
    nal_alu u_alu (
        .op_i(op_reg),
        .a_i(temp_a),
        .b_i(temp_b),
        .carry_i(status_word_reg[nal_pkg::BIT_CARRY]), // RULE12
        .decimal_i(status_word_reg[nal_pkg::BIT_DECIMAL]), // RULE12
        .result_o(alu_result),
        .carry_o(alu_carry),
        .skip_o(alu_skip)
    );

    // Class decode of the held operation.
    always_comb
    begin
        is_arith = (op_reg == nal_pkg::OP_ADD) || (op_reg == nal_pkg::OP_ADDC) ||
                   (op_reg == nal_pkg::OP_SUB) || (op_reg == nal_pkg::OP_SUBC);
        is_logic = (op_reg == nal_pkg::OP_OR) || (op_reg == nal_pkg::OP_AND) ||
                   (op_reg == nal_pkg::OP_XOR);
        is_test = (op_reg == nal_pkg::OP_TEST_ONES) || (op_reg == nal_pkg::OP_TEST_ZEROS);
        is_rotate = (op_reg == nal_pkg::OP_ROTATE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // One idle cycle to latch, one execute cycle to commit.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            nal_pkg::ST_IDLE:
                if (start_i)
                    state_next = nal_pkg::ST_EXEC;
            nal_pkg::ST_EXEC:
                state_next = nal_pkg::ST_IDLE;
            default:
                state_next = nal_pkg::ST_IDLE;
        endcase
    end

    assign commit = (state_reg == nal_pkg::ST_EXEC);

    // State register.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_reg <= nal_pkg::ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Operation and destination are held with the operands.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            op_reg <= nal_pkg::OP_ADD;
            dest_mem_reg <= 1'b0;
        end
        else if (accept)
        begin
            op_reg <= op_i;
            dest_mem_reg <= dest_mem_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status word and flag update

    // Software write first, then the ALU update of the flags this operation owns,
    // so a flag the instruction changes wins over a same-cycle software write.
    always_comb
    begin
        status_word_next = status_word_reg;
        if (apb_write && paddr_i == nal_pkg::ADDR_STATUS_WORD && pstrb_i[0])
            status_word_next = pwdata_i[3:0]; // RULE12
        if (commit)
        begin
            if (is_arith)
            begin
                status_word_next[nal_pkg::BIT_CARRY] = alu_carry; // RULE4 RULE7
                if (!status_word_reg[nal_pkg::BIT_NO_STORE])
                    status_word_next[nal_pkg::BIT_NULL] = (alu_result == 4'h0); // RULE1 RULE3
                else if (alu_result != 4'h0)
                    status_word_next[nal_pkg::BIT_NULL] = 1'b0; // RULE2
            end
            else if (is_rotate)
                status_word_next[nal_pkg::BIT_CARRY] = alu_carry; // RULE6 RULE7
            else if (is_test)
                status_word_next[nal_pkg::BIT_NO_STORE] = 1'b0; // RULE9
        end
    end

    // One register holds both the ALU flags and the status word.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            status_word_reg <= nal_pkg::STATUS_WORD_RESET;
        else
            status_word_reg <= status_word_next; // RULE12 RULE16
    end

    assign null_flag_o = status_word_reg[nal_pkg::BIT_NULL];
    assign carry_flag_o = status_word_reg[nal_pkg::BIT_CARRY];
    assign no_store_flag_o = status_word_reg[nal_pkg::BIT_NO_STORE];
    assign decimal_flag_o = status_word_reg[nal_pkg::BIT_DECIMAL];

    ////////////////////////////////////////////////////////////////////////////////
    // Result write control

    // Result and skip are captured at the commit edge, with the flags.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            result_reg <= nal_pkg::RESULT_RESET;
            skip_reg <= 1'b0;
        end
        else if (commit)
        begin
            result_reg <= alu_result; // RULE16
            skip_reg <= alu_skip; // RULE15
        end
        else
            skip_reg <= 1'b0;
    end

    // Write pulses: arithmetic stores only with no_store clear, logic and rotate
    // always store, tests and compares never do.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            gr_write_reg <= 1'b0;
            mem_write_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            done_reg <= commit; // RULE16
            if (commit && is_arith && !status_word_reg[nal_pkg::BIT_NO_STORE])
            begin
                gr_write_reg <= !dest_mem_reg; // RULE8
                mem_write_reg <= dest_mem_reg; // RULE8
            end
            else if (commit && is_logic)
            begin
                gr_write_reg <= !dest_mem_reg; // RULE17 RULE10
                mem_write_reg <= dest_mem_reg; // RULE17
            end
            else if (commit && is_rotate)
            begin
                gr_write_reg <= 1'b1; // RULE6 RULE10
                mem_write_reg <= 1'b0;
            end
            else
            begin
                gr_write_reg <= 1'b0;
                mem_write_reg <= 1'b0;
            end
        end
    end

    assign result_o = result_reg;
    assign skip_o = skip_reg;
    assign done_o = done_reg;
    assign gr_write_o = gr_write_reg;
    assign mem_write_o = mem_write_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave

    // Read data is gathered in the setup cycle so the access phase answers at once.
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pwrite_i;
    assign apb_mapped = (paddr_i == nal_pkg::ADDR_STATUS_WORD) ||
                        (paddr_i == nal_pkg::ADDR_LAST_RESULT);
    assign pready_o = 1'b1;

    // Read data and error flag.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prdata_reg <= 32'h0;
            pslverr_reg <= 1'b0;
        end
        else if (apb_setup)
        begin
            pslverr_reg <= !apb_mapped;
            if (paddr_i == nal_pkg::ADDR_STATUS_WORD)
                prdata_reg <= {28'h0, status_word_next}; // RULE12
            else if (paddr_i == nal_pkg::ADDR_LAST_RESULT)
            begin
                prdata_reg <= {28'h0, result_reg};
                prdata_reg[nal_pkg::LAST_SKIP_BIT] <= skip_reg;
                prdata_reg[nal_pkg::LAST_BUSY_BIT] <= !ready_o;
            end
            else
                prdata_reg <= 32'h0;
        end
    end

    assign prdata_o = prdata_reg;
    assign pslverr_o = pslverr_reg && psel_i && penable_i;

endmodule : nal_status_alu

// ---- tb/nal_partner.sv ----
// Far side model: the general register and one data memory nibble.
// Assumes write pulses and result come from the status ALU top.
`timescale 1ns/100ps
////////////////
module nal_partner (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    // Store requests.
    input wire logic gr_write_i,
    input wire logic mem_write_i,
    input wire logic [3:0] result_i,
    // Stored contents.
    output logic [3:0] gr_o,
    output logic [3:0] mem_o
);
    // Each copy changes only on its own write pulse.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            gr_o <= 4'h0;
            mem_o <= 4'h0;
        end
        else
        begin
            if (gr_write_i)
                gr_o <= result_i;
            if (mem_write_i)
                mem_o <= result_i;
        end
    end
endmodule : nal_partner

// ---- tb/nal_status_alu_properties.sv ----
// Concurrent checks on the ports of the nibble ALU status top.
// Assumes one clock, an active-low async reset and the bind at the foot.
`timescale 1ns/100ps
////////////////
module nal_status_alu_properties (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic resetn_i,
    // Instruction side.
    input wire logic start_i,
    input wire nal_pkg::nal_op_t op_i,
    input wire logic [3:0] first_i,
    input wire logic [3:0] second_i,
    input wire logic ready_o,
    input wire logic done_o,
    input wire logic [3:0] result_o,
    input wire logic gr_write_o,
    input wire logic mem_write_o,
    input wire logic skip_o,
    // Flags and bus select.
    input wire logic null_flag_o,
    input wire logic carry_flag_o,
    input wire logic no_store_flag_o,
    input wire logic decimal_flag_o,
    input wire logic psel_i
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    // Accepted instruction; quiet means no bus write can touch the flags.
    wire go = start_i && ready_o;
    wire quiet = !psel_i;
    wire arith = op_i < nal_pkg::OP_OR;
    wire [3:0] flags = {decimal_flag_o, no_store_flag_o, carry_flag_o, null_flag_o};
    logic [3:0] a_q;
    logic [3:0] b_q;
    logic c_q;
    wire [4:0] sum = {1'h0, a_q} + {1'h0, b_q};
    // Keeps the operands and carry seen when an instruction is accepted.
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            a_q <= 4'h0;
            b_q <= 4'h0;
            c_q <= 1'h0;
        end
        else if (go)
        begin
            a_q <= first_i;
            b_q <= second_i;
            c_q <= carry_flag_o;
        end
    end
    ////////////////
    a_exec_then_done: assert property (go |=> !ready_o ##1 (done_o && ready_o))
        else $error("done pulse late");
    a_pulse_in_done: assert property ((gr_write_o || mem_write_o || skip_o) |-> done_o)
        else $error("pulse without done");
    a_test_clears: assert property (go && (op_i == nal_pkg::OP_TEST_ONES ||
        op_i == nal_pkg::OP_TEST_ZEROS) |=> ##1 (!no_store_flag_o && !gr_write_o && !mem_write_o))
        else $error("bit test left no-store or wrote");
    a_store_blocked: assert property (go && arith && no_store_flag_o && quiet ##1 quiet
        |=> !gr_write_o && !mem_write_o) else $error("suppressed result written");
    a_logic_holds: assert property (go && quiet && (op_i inside {nal_pkg::OP_OR,
        nal_pkg::OP_AND, nal_pkg::OP_XOR}) ##1 quiet |=> $stable(flags) && (gr_write_o || mem_write_o))
        else $error("logic op changed flags or skipped write");
    a_rotate_bits: assert property (go && op_i == nal_pkg::OP_ROTATE && quiet ##1 quiet
        |=> gr_write_o && carry_flag_o == a_q[0] && result_o == {c_q, a_q[3:1]})
        else $error("rotate through carry wrong");
    a_add_sum: assert property (go && op_i == nal_pkg::OP_ADD && !decimal_flag_o && quiet
        ##1 quiet |=> carry_flag_o == sum[4] && result_o == sum[3:0]) else $error("binary add wrong");
    a_null_plain: assert property (go && arith && !no_store_flag_o && quiet ##1 quiet
        |=> null_flag_o == (result_o == 4'h0)) else $error("null flag wrong");
    a_null_kept: assert property (go && arith && no_store_flag_o && quiet ##1 quiet
        |=> null_flag_o == (result_o == 4'h0 && $past(null_flag_o, 2))) else $error("null not kept");
    a_skip_equal: assert property (go && op_i == nal_pkg::OP_SKIP_EQ
        |=> ##1 skip_o == (a_q == b_q)) else $error("equal skip wrong");
    // Main scenarios reached.
    c_rotate: cover property (go && op_i == nal_pkg::OP_ROTATE);
    c_suppressed: cover property (done_o && no_store_flag_o && !gr_write_o && !mem_write_o);
    c_skip: cover property (skip_o);
endmodule : nal_status_alu_properties
bind nal_status_alu nal_status_alu_properties u_props (.*);

// ---- tb/nal_status_alu_test.sv ----
// Self-checking bench for the nibble ALU status top.
// Assumes the package, the design, the checker and the partner are compiled first.
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
////////////////
module nal_status_alu_test;
    // One row: op, dest, operands, status before, result, flags, writes, skip, check.
    typedef struct packed {
        logic [3:0] op, dm, a, b, st, res, fl, wr, sk, cr;
    } nal_row_t;
    nal_row_t rows [20] = '{
        40'h0079003201,
        40'h1034280201,
        40'h21350e2101,
        40'h30552f2201,
        40'h0088507001,
        40'h0012534001,
        40'h007582a201,
        40'h202587a201,
        40'h405afff201,
        40'h5163525101,
        40'h60f50a0201,
        40'h7073703010,
        40'h7053400000,
        40'h8043400010,
        40'h9055808010,
        40'ha055404000,
        40'hb034000000,
        40'hc034202010,
        40'hd1602b0201,
        40'hd090c4e201};
    // Design inputs, all given at time zero.
    logic clock_i = 0, resetn_i = 0, start_i = 0, dest_mem_i = 0;
    nal_pkg::nal_op_t op_i = nal_pkg::OP_ADD;
    logic [3:0] first_i = 4'h0, second_i = 4'h0, pstrb_i = 4'hf;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    // Design outputs and bench state.
    logic ready_o, done_o, gr_write_o, mem_write_o, skip_o, pready_o, pslverr_o, er;
    logic null_flag_o, carry_flag_o, no_store_flag_o, decimal_flag_o;
    logic [3:0] result_o, gr_q, mem_q;
    logic [31:0] prdata_o, rd;
    int err_total = 0, n_compared = 0;
    always #25 clock_i = ~clock_i;
    nal_status_alu dut (.*);
    nal_partner far_side (.clock_i(clock_i), .resetn_i(resetn_i), .gr_write_i(gr_write_o),
        .mem_write_i(mem_write_o), .result_i(result_o), .gr_o(gr_q), .mem_o(mem_q));
    ////////////////
    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clock_i);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= ad;
        pwdata_i <= wd;
        @(posedge clock_i);
        penable_i <= 1'h1;
        do @(posedge clock_i); while (pready_o !== 1'h1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
    endtask : apb
    // Starts one instruction and waits, bounded, for its done pulse.
    task automatic run(input nal_row_t r);
        @(posedge clock_i);
        start_i <= 1'h1;
        op_i <= nal_pkg::nal_op_t'(r.op);
        dest_mem_i <= r.dm[0];
        first_i <= r.a;
        second_i <= r.b;
        @(posedge clock_i);
        start_i <= 1'h0;
        for (int k = 0; k < 8 && done_o !== 1'h1; k++)
            @(posedge clock_i) #1;
    endtask : run
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results
    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        results();
    end
    // Main sequence: reset, table, then the awkward cases.
    initial
    begin
        repeat (20) @(posedge clock_i);
        resetn_i <= 1'h1;
        @(posedge clock_i) #1;
        `CHK({ready_o, done_o, null_flag_o, carry_flag_o}, 4'h8)
        foreach (rows[i])
        begin
            apb(1'h1, 8'h00, {28'h0, rows[i].st});
            run(rows[i]);
            `CHK(skip_o, rows[i].sk[0])
            `CHK({gr_write_o, mem_write_o}, rows[i].wr[1:0])
            `CHK({decimal_flag_o, no_store_flag_o, carry_flag_o, null_flag_o}, rows[i].fl)
            if (rows[i].cr)
                `CHK(result_o, rows[i].res)
            apb(1'h0, 8'h00, 32'h0);
            `CHK(rd[3:0], rows[i].fl)
            if (rows[i].wr != 4'h0)
                `CHK(rows[i].wr[1] ? gr_q : mem_q, rows[i].res)
        end
        // Unmapped place refused; read-only place leaves the status word alone.
        apb(1'h1, 8'h08, 32'hf);
        `CHK(er, 1'h1)
        apb(1'h1, 8'h04, 32'hf);
        apb(1'h0, 8'h04, 32'h0);
        `CHK(rd, 32'h4)
        apb(1'h0, 8'h00, 32'h0);
        `CHK(rd, 32'he)
        // Start held through execute: the refused copy must not run early.
        @(posedge clock_i);
        start_i <= 1'h1;
        op_i <= nal_pkg::OP_ADD;
        first_i <= 4'hf;
        second_i <= 4'h1;
        @(posedge clock_i);
        op_i <= nal_pkg::OP_ADDC;
        first_i <= 4'h0;
        second_i <= 4'h0;
        @(posedge clock_i);
        start_i <= 1'h0;
        #1;
        `CHK({done_o, result_o, carry_flag_o, null_flag_o}, 7'h5a)
        // Reset during execute clears the flags and drops the commit.
        run(rows[0]);
        @(posedge clock_i);
        start_i <= 1'h1;
        @(posedge clock_i);
        start_i <= 1'h0;
        resetn_i <= 1'h0;
        @(posedge clock_i) #1;
        `CHK({ready_o, done_o, carry_flag_o, null_flag_o}, 4'h8)
        resetn_i <= 1'h1;
        results();
    end
endmodule : nal_status_alu_test
